// file: oapg_bank.sv
// Path selection, channel gain and integration option register bank
module oapg_bank
	import oapg_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Register access
	input wire oapg_req_s req_in,
	output logic [15:0] rdata_out,
	// Settings held elsewhere in the device
	input wire logic slot_a_individual_gain_enable_in,
	input wire logic slot_b_individual_gain_enable_in,
	input wire logic [1:0] slot_a_gain_in,
	input wire logic [1:0] slot_b_gain_in,
	input wire logic [OAPG_FOFS_W-1:0] slot_a_fine_offset_in,
	input wire logic [OAPG_FOFS_W-1:0] slot_b_fine_offset_in,
	input wire logic slot_a_integration_mode_enable_in,
	input wire logic slot_b_integration_mode_enable_in,
	// Effective front-end settings, slot A in index 0
	output oapg_slot_s [1:0] slot_out,
	output oapg_path_e slot_a_path_out,
	output logic slot_a_path_reserved_out,
	output logic [2:0] extra_channel_powerdown_out
);

	// ----------------------------------------------------------------
	// Slot-indexed views of the inputs
	// ----------------------------------------------------------------
	logic [1:0] ind_en;
	logic [1:0][1:0] slot_gain;
	logic [1:0][OAPG_FOFS_W-1:0] fofs;
	logic [1:0] integ_en;
	logic [1:0][3:0][1:0] gain_res;
	logic integ_any;

	assign ind_en = {slot_b_individual_gain_enable_in, slot_a_individual_gain_enable_in};
	assign slot_gain = {slot_b_gain_in, slot_a_gain_in};
	assign fofs = {slot_b_fine_offset_in, slot_a_fine_offset_in};
	assign integ_en = {slot_b_integration_mode_enable_in, slot_a_integration_mode_enable_in};

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [15:0] path_r, path_nxt;
	logic [15:0] gain_r, gain_nxt;
	logic [15:0] opt_r, opt_nxt;
	logic [15:0] rdata_nxt;
	logic acc_wr;

	assign acc_wr = ce_in && req_in.wr;

	always_comb
	begin
		path_nxt = path_r;
		gain_nxt = gain_r;
		opt_nxt = opt_r;
		rdata_nxt = rdata_out;
		// Reserved bits are kept as written so a read-back matches
		if (acc_wr && req_in.addr == OAPG_PATH_OFS)
			path_nxt = req_in.wdata;
		if (acc_wr && req_in.addr == OAPG_GAIN_OFS)
			gain_nxt = req_in.wdata;
		if (acc_wr && req_in.addr == OAPG_OPT_OFS)
			opt_nxt = req_in.wdata;
		if (ce_in && req_in.rd)
		begin
			unique case (req_in.addr)
				OAPG_PATH_OFS: rdata_nxt = path_r;
				OAPG_GAIN_OFS: rdata_nxt = gain_r;
				OAPG_OPT_OFS: rdata_nxt = opt_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			path_r <= OAPG_PATH_RST;
			gain_r <= OAPG_GAIN_RST;
			opt_r <= OAPG_OPT_RST;
			rdata_out <= 16'h0000;
		end
		else
		begin
			path_r <= path_nxt;
			gain_r <= gain_nxt;
			opt_r <= opt_nxt;
			rdata_out <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Gain resolution per slot
	// ----------------------------------------------------------------
	for (genvar s = 0; s < 2; s++)
	begin : g_slot
		localparam int LSB = (s == 0) ? OAPG_SA_CH2_LSB : OAPG_SB_CH2_LSB;
		oapg_gain_sel u_sel (
			.ind_en_in(ind_en[s]),
			.slot_gain_in(slot_gain[s]),
			.ind_gain_in(gain_r[LSB +: 6]),
			.gain_out(gain_res[s])
		);
	end

	// ----------------------------------------------------------------
	// Output settings
	// ----------------------------------------------------------------
	oapg_slot_s [1:0] slot_nxt;
	oapg_path_e path_dec_nxt;
	logic [2:0] pwr_nxt;

	// For channel power-down only, slot A also counts as integrating when its path code selects integration
	assign integ_any = (|integ_en) || (oapg_path_decode(path_r) == OAPG_PATH_INTEG);

	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			slot_nxt[s].gain = gain_res[s];
			slot_nxt[s].integ = integ_en[s];
			// Fine offset steps are 31.25 ns; the gap reuses the same field
			slot_nxt[s].gap = opt_r[OAPG_GAP_BIT] ? fofs[s] : '0;
		end
		slot_nxt[0].single_pair = integ_en[0] && opt_r[OAPG_SA_PAIR_BIT];
		slot_nxt[1].single_pair = integ_en[1] && opt_r[OAPG_SB_PAIR_BIT];
		path_dec_nxt = oapg_path_decode(path_r);
		pwr_nxt = integ_any ? gain_r[OAPG_PWR_LSB +: 3] : 3'h0;
		if (!ce_in)
		begin
			slot_nxt = slot_out;
			path_dec_nxt = slot_a_path_out;
			pwr_nxt = extra_channel_powerdown_out;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			slot_out <= '0;
			slot_a_path_out <= OAPG_PATH_FULL;
			extra_channel_powerdown_out <= 3'h0;
		end
		else
		begin
			slot_out <= slot_nxt;
			slot_a_path_out <= path_dec_nxt;
			extra_channel_powerdown_out <= pwr_nxt;
		end
	end

	assign slot_a_path_reserved_out = (slot_a_path_out == OAPG_PATH_RSVD);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_PATH_INTEG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && path_r == OAPG_CODE_INTEG |=> slot_a_path_out == OAPG_PATH_INTEG)
		else $error("Integration path code not decoded");
	AST_PWR_ALL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && integ_any && gain_r[15:13] == 3'h7 |=> extra_channel_powerdown_out == 3'h7)
		else $error("Channels 2-4 not powered down");
	AST_PWR_NONE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && gain_r[15:13] == 3'h0 |=> extra_channel_powerdown_out == 3'h0)
		else $error("Channel powered down with field zero");
	AST_B_CH4: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && ind_en[1] |=> slot_out[1].gain[3] == $past(gain_r[11:10]))
		else $error("Slot B channel 4 gain wrong");
	AST_A_CH2: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && ind_en[0] |=> slot_out[0].gain[1] == $past(gain_r[1:0]))
		else $error("Slot A channel 2 gain wrong");
	AST_COMMON: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && !ind_en[0] |=> slot_out[0].gain[3] == $past(slot_gain[0])
		&& slot_out[0].gain[2] == slot_out[0].gain[0])
		else $error("Slot gain not applied to all channels");
	AST_NO_GAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && !opt_r[7] |=> slot_out[0].gap == '0 && slot_out[1].gap == '0)
		else $error("Gap present with gapped mode off");
	AST_GAP_B: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && opt_r[7] |=> slot_out[1].gap == $past(fofs[1]))
		else $error("Slot B gap not taken from fine offset");
	AST_PAIR_B: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && integ_en[1] |=> slot_out[1].single_pair == $past(opt_r[6]))
		else $error("Slot B pair mode wrong");
	AST_PAIR_A: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && integ_en[0] |=> slot_out[0].single_pair == $past(opt_r[5]))
		else $error("Slot A pair mode wrong");
	AST_INTEG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in |=> slot_out[1].integ == $past(integ_en[1]) && slot_out[0].integ == $past(integ_en[0]))
		else $error("Integration enable not followed");
	AST_READBACK: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && req_in.wr && !req_in.rd && req_in.addr == OAPG_OPT_OFS
		##1 ce_in && req_in.rd && !req_in.wr && req_in.addr == OAPG_OPT_OFS
		|=> rdata_out == $past(req_in.wdata, 2))
		else $error("Option register read-back differs from write");
	AST_PATH_DIRECT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && path_r == OAPG_CODE_DIRECT |=> slot_a_path_out == OAPG_PATH_DIRECT)
		else $error("Direct path code not decoded");
	AST_PATH_RSVD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && path_r != OAPG_CODE_FULL && path_r != OAPG_CODE_DIRECT
		&& path_r != OAPG_CODE_INTEG |=> slot_a_path_reserved_out)
		else $error("Reserved path code not flagged");
	AST_CH1: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in |=> slot_out[0].gain[0] == $past(slot_gain[0])
		&& slot_out[1].gain[0] == $past(slot_gain[1]))
		else $error("Channel 1 gain is not the slot gain");
	AST_B_CH2: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && ind_en[1] |=> slot_out[1].gain[1] == $past(gain_r[7:6]))
		else $error("Slot B channel 2 gain wrong");
	AST_A_CH4: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && ind_en[0] |=> slot_out[0].gain[3] == $past(gain_r[5:4]))
		else $error("Slot A channel 4 gain wrong");
	AST_GAP_A: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && opt_r[7] |=> slot_out[0].gap == $past(fofs[0]))
		else $error("Slot A gap not taken from fine offset");
	AST_PAIR_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in |=> (!slot_out[0].single_pair || $past(integ_en[0]))
		&& (!slot_out[1].single_pair || $past(integ_en[1])))
		else $error("Single pair mode outside integration");
	AST_WR_GAIN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ce_in && req_in.wr && req_in.addr == OAPG_GAIN_OFS
		|=> gain_r == $past(req_in.wdata))
		else $error("Gain register write not stored");
	AST_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!ce_in |=> $stable(path_r) && $stable(gain_r) && $stable(opt_r) && $stable(slot_out))
		else $error("State changed with clock enable low");

endmodule // oapg_bank

// file: oapg_pkg.sv
// Constants, types and decode helper for the optical front-end path and gain register bank
// ----------------------------------------------------------------
// Function
// - Slot A path register takes 0xada5 full chain, 0xb065 direct, 0xae65 integration.
// - Power-down field [15:13]: 0 keeps all powered, 7 powers down channels 2-4; applied only while a slot integrates or the path code selects integration.
// - Slot B channel 4/3/2 gains sit in bits [11:10], [9:8], [7:6].
// - Slot A channel 4/3/2 gains sit in bits [5:4], [3:2], [1:0].
// - Gain codes 0..3 mean 200k, 100k, 50k, 25k ohm; fields reset to 0.
// - Gap bit 7 clear means no gap; set uses slot fine offset as gap.
// - Slot B pair-mode bit 6: 0 double, 1 single sample pair in integration.
// - Slot A pair-mode bit 5: 0 double, 1 single sample pair in integration.
// - Fine offset per slot is five bits in 31.25 ns steps.
// - Channel 2-4 gains apply only with individual enable; else slot gain for all.
// - Integration enable: slot B bit 13, slot A bit 12; 0 means normal.
// ----------------------------------------------------------------
package oapg_pkg;

	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OAPG_PATH_OFS = 8'h43;
	localparam logic [7:0] OAPG_GAIN_OFS = 8'h55;
	localparam logic [7:0] OAPG_OPT_OFS = 8'h5a;
	localparam logic [15:0] OAPG_PATH_RST = 16'hada5;
	localparam logic [15:0] OAPG_GAIN_RST = 16'h0000;
	localparam logic [15:0] OAPG_OPT_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Path codes
	// ----------------------------------------------------------------
	localparam logic [15:0] OAPG_CODE_FULL = 16'hada5;
	localparam logic [15:0] OAPG_CODE_DIRECT = 16'hb065;
	localparam logic [15:0] OAPG_CODE_INTEG = 16'hae65;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OAPG_PWR_LSB = 13;
	localparam int OAPG_SB_CH2_LSB = 6;
	localparam int OAPG_SA_CH2_LSB = 0;
	localparam int OAPG_GAP_BIT = 7;
	localparam int OAPG_SB_PAIR_BIT = 6;
	localparam int OAPG_SA_PAIR_BIT = 5;
	localparam int OAPG_FOFS_W = 5;
	localparam int OAPG_FOFS_STEP_PS = 31250;

	typedef enum logic [1:0] {OAPG_GAIN_200K, OAPG_GAIN_100K, OAPG_GAIN_50K, OAPG_GAIN_25K}
		oapg_gain_e;

	typedef enum logic [1:0] {OAPG_PATH_FULL, OAPG_PATH_DIRECT, OAPG_PATH_INTEG,
		OAPG_PATH_RSVD} oapg_path_e;

	// Register access request from the host-side interface logic
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} oapg_req_s;

	// Effective settings of one time slot
	typedef struct packed {
		logic [3:0][1:0] gain;
		logic [OAPG_FOFS_W-1:0] gap;
		logic single_pair;
		logic integ;
	} oapg_slot_s;

	function automatic oapg_path_e oapg_path_decode(input logic [15:0] code);
		oapg_path_e p;
		p = OAPG_PATH_RSVD;
		if (code == OAPG_CODE_FULL)
			p = OAPG_PATH_FULL;
		else if (code == OAPG_CODE_DIRECT)
			p = OAPG_PATH_DIRECT;
		else if (code == OAPG_CODE_INTEG)
			p = OAPG_PATH_INTEG;
		return p;
	endfunction

endpackage

// file: oapg_gain_sel.sv
// Per-slot transimpedance gain resolver for channels 1 to 4
module oapg_gain_sel
	import oapg_pkg::*;
(
	// Slot controls
	input wire logic ind_en_in,
	input wire logic [1:0] slot_gain_in,
	input wire logic [5:0] ind_gain_in,
	// Resolved gains, channel 1 in index 0
	output logic [3:0][1:0] gain_out
);

	always_comb
	begin
		gain_out[0] = slot_gain_in;
		for (int i = 1; i < 4; i++)
		begin
			gain_out[i] = ind_en_in ? ind_gain_in[2*(i-1) +: 2] : slot_gain_in;
		end
	end

endmodule // oapg_gain_sel

// file: tb_top.sv
// Self-checking testbench for the path, gain and integration option register bank
module tb_top
	import oapg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Stimulus, responses and register shadows
	// ----------------------------------------------------------------
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	oapg_req_s req = '0;
	logic [15:0] rdata;
	logic ia = 1'b0, ib = 1'b0, ea = 1'b0, eb = 1'b0;
	logic [1:0] ga = 2'h0, gb = 2'h0;
	logic [4:0] fa = 5'h00, fb = 5'h00;
	oapg_slot_s [1:0] slot;
	oapg_path_e path;
	logic rsv;
	logic [2:0] pd;
	oapg_slot_s [1:0] held;
	int errors = 0;
	int compares = 0;
	integer seed = 32'h6b8be139;
	logic [15:0] gain_m = 16'h0000, opt_m = 16'h0000, path_m = 16'hada5;
	logic [15:0] codes [4] = '{16'hada5, 16'hb065, 16'hae65, 16'h1234};
	oapg_path_e kinds [4] = '{OAPG_PATH_FULL, OAPG_PATH_DIRECT, OAPG_PATH_INTEG, OAPG_PATH_RSVD};

	always #20 sys_clk_in = ~sys_clk_in;

	oapg_bank oapg_bank_i (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.req_in(req), .rdata_out(rdata),
		.slot_a_individual_gain_enable_in(ia), .slot_b_individual_gain_enable_in(ib),
		.slot_a_gain_in(ga), .slot_b_gain_in(gb),
		.slot_a_fine_offset_in(fa), .slot_b_fine_offset_in(fb),
		.slot_a_integration_mode_enable_in(ea), .slot_b_integration_mode_enable_in(eb),
		.slot_out(slot), .slot_a_path_out(path), .slot_a_path_reserved_out(rsv),
		.extra_channel_powerdown_out(pd)
	);

	// ----------------------------------------------------------------
	// Checks, bus cycles and expectations
	// ----------------------------------------------------------------
	task results;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request is left up; idle drops it, so no signal is set twice in one step
	task wr(input logic [7:0] a, input logic [15:0] d);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk_in);
	endtask

	task idle(input int n);
		req = '0;
		repeat (n) @(negedge sys_clk_in);
	endtask

	task rdchk(input logic [7:0] a, input logic [15:0] exp);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge sys_clk_in);
		chk(rdata, exp);
	endtask

	function automatic oapg_slot_s exp_slot(input logic ind, input logic [1:0] g,
		input logic [5:0] f, input logic [4:0] fo, input logic en, input logic pb);
		oapg_slot_s s;
		s.gain[0] = g;
		for (int i = 1; i < 4; i++)
			s.gain[i] = ind ? f[2*i-2 +: 2] : g;
		s.gap = opt_m[7] ? fo : 5'h00;
		s.single_pair = en & pb;
		s.integ = en;
		return s;
	endfunction

	task chk_out;
		chk(slot[0], exp_slot(ia, ga, gain_m[5:0], fa, ea, opt_m[5]));
		chk(slot[1], exp_slot(ib, gb, gain_m[11:6], fb, eb, opt_m[6]));
		chk(pd, (ea | eb | (path_m == 16'hae65)) ? gain_m[15:13] : 3'h0);
	endtask

	task chk_regs;
		rdchk(OAPG_PATH_OFS, path_m);
		rdchk(OAPG_GAIN_OFS, gain_m);
		rdchk(OAPG_OPT_OFS, opt_m);
		idle(1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		@(negedge sys_clk_in);
		chk(path, OAPG_PATH_FULL);
		chk_out();
		chk_regs();
		for (int i = 0; i < 40; i++)
		begin
			{ia, ib, ea, eb} = 4'($random(seed));
			{ga, gb, fa, fb} = 14'($random(seed));
			gain_m = 16'($random(seed)) & 16'hefff;
			opt_m = 16'($random(seed)) & 16'h00e0;
			if (i < 2)
				gain_m[15:13] = 3'h7;
			if (i < 2)
				{ea, eb} = {~i[0], 1'b0};
			wr(OAPG_GAIN_OFS, gain_m);
			wr(OAPG_OPT_OFS, opt_m);
			rdchk(OAPG_OPT_OFS, opt_m);
			idle(1);
			chk_out();
			rdchk(OAPG_GAIN_OFS, gain_m);
			rdchk(OAPG_OPT_OFS, opt_m);
		end
		{ea, eb} = 2'b00;
		gain_m[15:13] = 3'h7;
		wr(OAPG_GAIN_OFS, gain_m);
		for (int k = 0; k < 4; k++)
		begin
			path_m = codes[k];
			wr(OAPG_PATH_OFS, path_m);
			idle(2);
			chk(path, kinds[k]);
			chk(rsv, k == 3);
			chk_out();
			rdchk(OAPG_PATH_OFS, path_m);
		end
		wr(8'h44, 16'hffff);
		rdchk(8'h44, 16'h0000);
		chk_regs();
		ce_in = 1'b0;
		held = slot;
		ga = ~ga;
		wr(OAPG_GAIN_OFS, ~gain_m & 16'hefff);
		idle(1);
		chk(slot, held);
		ce_in = 1'b1;
		chk_regs();
		chk_out();
		rst_n_in = 1'b0;
		@(negedge sys_clk_in);
		rst_n_in = 1'b1;
		{gain_m, opt_m, path_m} = {16'h0000, 16'h0000, 16'hada5};
		@(negedge sys_clk_in);
		chk_out();
		chk_regs();
		results();
	end

	// Whole run is a few hundred cycles; this is far beyond it
	initial
	begin
		#200000;
		errors++;
		results();
	end

endmodule // tb_top
